// file: rtl/ssp_pkg.sv
// Functional notes
// RQ1: two-wire transfers use standard fast-mode framing
// RQ2: 16-bit register address, then 8-bit data bytes
// RQ3: 0x0000-0x0fff decodes as configuration registers
// RQ4: 0x1000-0x1fff static limits, writes have no effect
// RQ5: 0x2000-0x2fff reserved, 0x3000-0xffff maker specific
// RQ6: control and status registers reachable over link
// RQ7: strap level picks the device slave address
// RQ8: device answers only its own selected address
// RQ9: direction bit 0 writes, 1 reads
// RQ10: host keeps the chosen address unique
// RQ11: host programs sensor setup before expecting image
// RQ12: flagged registers mirrored into two embedded lines
// RQ13: embedded bytes unspecified while mirroring is off
// RQ14: 14-bit luminance averages readable over link
// RQ15: one input pin selects the slave address
// RQ16: both selectable slave addresses are build parameters
// RQ17: register pointer steps by one per byte
package ssp_pkg;
  // ****************************************
  // region decode
  // ****************************************
  localparam logic [3:0]  REGION_CFG       = 4'h0;
  localparam logic [3:0]  REGION_LIMIT     = 4'h1;
  localparam logic [3:0]  REGION_RESERVED  = 4'h2;
  localparam logic [15:0] STATS_BASE       = 16'h3000;
  localparam logic [15:0] ID_HI_ADDR       = 16'h0000;
  localparam logic [15:0] ID_LO_ADDR       = 16'h0001;
  localparam logic [15:0] EMB_CTRL_ADDR    = 16'h0010;
  localparam int          EMB_EN_BIT       = 0;
  localparam int          EMB_LINES        = 2;
  localparam int          STATS_WIDTH      = 14;
  localparam logic [7:0]  RESET_BYTE       = 8'h00;
  // ****************************************
  // link timing
  // ****************************************
  localparam int          CLK_FREQ_KHZ     = 125000;
  localparam int          SCL_FREQ_KHZ     = 400;
  localparam int          QTR_CYCLES       = (CLK_FREQ_KHZ + 4 * SCL_FREQ_KHZ - 1) / (4 * SCL_FREQ_KHZ);
endpackage

// file: rtl/ssp_if.sv
`timescale 1ns/10ps
interface ssp_if;
  logic scl;
  logic sda;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  // open drain: any enabled driver with a low output pulls low, else pulled up
  assign scl = !((host_scl_oe && !host_scl_o) || (dev_scl_oe && !dev_scl_o));
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
  modport device (input scl, input sda, output dev_scl_o, output dev_scl_oe, output dev_sda_o, output dev_sda_oe);
  modport host   (input scl, input sda, output host_scl_o, output host_scl_oe, output host_sda_o, output host_sda_oe);
endinterface

// file: rtl/ssp_device.sv
`timescale 1ns/10ps
module ssp_device #(
  parameter logic [6:0]  ADDR_STRAP_LOW  = 7'h10,
  parameter logic [6:0]  ADDR_STRAP_HIGH = 7'h1a,
  parameter int          CFG_DEPTH       = 64,
  parameter int          STATS_N         = 16,
  parameter logic [15:0] MODEL_ID        = 16'h5a3c,
  parameter logic [31:0] LIMIT_WORD      = 32'h0000_0000,
  parameter logic [63:0] EMB_FLAGS       = 64'hffff_ffff_ffff_ffff
) (
  input  wire logic                              clk,
  input  wire logic                              reset,
  ssp_if.device                                  link,
  input  wire logic                              address_select_strap,
  input  wire logic [STATS_N*ssp_pkg::STATS_WIDTH-1:0] stats_avg,
  input  wire logic                              emb_rd,
  input  wire logic [7:0]                        emb_idx,
  output logic [7:0]                             emb_byte_q,
  output logic                                   emb_valid_q,
  output logic [CFG_DEPTH*8-1:0]                 cfg_q,
  output logic                                   busy
);
  // ****************************************
  // pin synchronisers and strap capture
  // ****************************************
  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_ADDR = 6'b00_0010,
    ST_ACK  = 6'b00_0100,
    ST_RECV = 6'b00_1000,
    ST_SEND = 6'b01_0000,
    ST_MACK = 6'b10_0000
  } ssp_dev_state_t;

  logic [2:0] scl_sync_q, scl_sync_d;
  logic [2:0] sda_sync_q, sda_sync_d;
  logic [1:0] strap_sync_q, strap_sync_d;
  logic       strap_done_q, strap_done_d;
  logic       strap_q, strap_d;
  logic       scl_s, sda_s, scl_rise, scl_fall, start_cond, stop_cond;
  logic [6:0] my_addr;

  always_comb begin
    scl_sync_d   = {scl_sync_q[1:0], link.scl};
    sda_sync_d   = {sda_sync_q[1:0], link.sda};
    strap_sync_d = {strap_sync_q[0], address_select_strap};
    strap_done_d = 1'b1;
    strap_d      = strap_done_q ? strap_q : strap_sync_q[1]; // RQ15
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      scl_sync_q   <= 3'b111;
      sda_sync_q   <= 3'b111;
      strap_done_q <= 1'b0;
      strap_q      <= 1'b0;
    end else begin
      scl_sync_q   <= scl_sync_d;
      sda_sync_q   <= sda_sync_d;
      strap_done_q <= strap_done_d;
      strap_q      <= strap_d;
    end
    // strap keeps syncing through reset, so the capture at release sees the real level
    strap_sync_q <= strap_sync_d;
  end

  // stage 0 only feeds stage 1; edges compare stages 1 and 2
  assign scl_s      = scl_sync_q[1];
  assign sda_s      = sda_sync_q[1];
  assign scl_rise   = scl_s && !scl_sync_q[2];
  assign scl_fall   = !scl_s && scl_sync_q[2];
  assign start_cond = scl_s && scl_sync_q[2] && !sda_s && sda_sync_q[2]; // RQ1
  assign stop_cond  = scl_s && scl_sync_q[2] && sda_s && !sda_sync_q[2];
  assign my_addr    = strap_q ? ADDR_STRAP_HIGH : ADDR_STRAP_LOW; // RQ7 RQ16

  // ****************************************
  // register space read mux
  // ****************************************
  logic [7:0] cfg_mem [CFG_DEPTH];
  logic [15:0] ptr_q, ptr_d;
  logic [7:0]  rd_data;
  logic [15:0] stats_off;
  logic [STATS_N*ssp_pkg::STATS_WIDTH-1:0] stats_sh;
  logic [15:0] stat_word;

  always_comb begin
    rd_data   = ssp_pkg::RESET_BYTE;
    stats_off = ptr_q - ssp_pkg::STATS_BASE;
    stats_sh  = stats_avg >> (ssp_pkg::STATS_WIDTH * int'(stats_off[15:1]));
    stat_word = {2'b00, stats_sh[ssp_pkg::STATS_WIDTH-1:0]};
    if (ptr_q == ssp_pkg::ID_HI_ADDR) begin
      rd_data = MODEL_ID[15:8];
    end else if (ptr_q == ssp_pkg::ID_LO_ADDR) begin
      rd_data = MODEL_ID[7:0];
    end else if (ptr_q[15:12] == ssp_pkg::REGION_CFG) begin // RQ3 RQ6
      rd_data = (ptr_q < 16'(CFG_DEPTH)) ? cfg_mem[ptr_q[$clog2(CFG_DEPTH)-1:0]] : ssp_pkg::RESET_BYTE;
    end else if (ptr_q[15:12] == ssp_pkg::REGION_LIMIT) begin // RQ4
      rd_data = LIMIT_WORD[8*ptr_q[1:0] +: 8];
    end else if (ptr_q[15:12] == ssp_pkg::REGION_RESERVED) begin // RQ5
      rd_data = ssp_pkg::RESET_BYTE;
    end else if (ptr_q >= ssp_pkg::STATS_BASE && stats_off < 16'(2 * STATS_N)) begin // RQ14
      rd_data = stats_off[0] ? stat_word[7:0] : stat_word[15:8];
    end
  end

  // ****************************************
  // slave state machine
  // ****************************************
  ssp_dev_state_t state_q, state_d;
  logic [3:0] bit_q, bit_d;
  logic [1:0] idx_q, idx_d;
  logic [7:0] sh_q, sh_d;
  logic       rw_q, rw_d;
  logic       oe_q, oe_d;
  logic       wr_en;

  always_comb begin
    state_d = state_q;
    bit_d   = bit_q;
    idx_d   = idx_q;
    sh_d    = sh_q;
    rw_d    = rw_q;
    oe_d    = oe_q;
    ptr_d   = ptr_q;
    wr_en   = 1'b0;
    if (start_cond) begin
      state_d = ST_ADDR;
      bit_d   = 4'h0;
      oe_d    = 1'b0;
    end else if (stop_cond) begin
      state_d = ST_IDLE;
      oe_d    = 1'b0;
    end else begin
      case (state_q)
        ST_ADDR, ST_RECV: begin
          if (scl_rise) begin
            sh_d  = {sh_q[6:0], sda_s};
            bit_d = bit_q + 4'h1;
          end else if (scl_fall && bit_q == 4'h8) begin
            if (state_q == ST_ADDR) begin
              if (sh_q[7:1] == my_addr) begin // RQ8
                rw_d    = sh_q[0]; // RQ9
                idx_d   = 2'd1;
                oe_d    = 1'b1;
                state_d = ST_ACK;
              end else begin
                state_d = ST_IDLE;
              end
            end else begin
              oe_d    = 1'b1;
              state_d = ST_ACK;
              case (idx_q)
                2'd1: ptr_d[15:8] = sh_q; // RQ2
                2'd2: ptr_d[7:0]  = sh_q;
                default: begin
                  wr_en = 1'b1;
                  ptr_d = ptr_q + 16'h0001; // RQ17
                end
              endcase
              idx_d = (idx_q == 2'd3) ? 2'd3 : idx_q + 2'd1;
            end
          end
        end
        ST_ACK, ST_MACK: begin
          if (scl_rise && state_q == ST_MACK && sda_s) begin
            state_d = ST_IDLE;
          end else if (scl_fall) begin
            bit_d = 4'h0;
            if (rw_q) begin
              sh_d    = rd_data;
              oe_d    = !rd_data[7];
              ptr_d   = ptr_q + 16'h0001; // RQ17
              state_d = ST_SEND;
            end else begin
              oe_d    = 1'b0;
              state_d = ST_RECV;
            end
          end
        end
        ST_SEND: begin
          if (scl_rise) begin
            bit_d = bit_q + 4'h1;
          end else if (scl_fall) begin
            if (bit_q == 4'h8) begin
              oe_d    = 1'b0;
              state_d = ST_MACK;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              oe_d = !sh_q[6];
            end
          end
        end
        default: oe_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      bit_q   <= 4'h0;
      idx_q   <= 2'd0;
      sh_q    <= 8'h00;
      rw_q    <= 1'b0;
      oe_q    <= 1'b0;
      ptr_q   <= 16'h0000;
    end else begin
      state_q <= state_d;
      bit_q   <= bit_d;
      idx_q   <= idx_d;
      sh_q    <= sh_d;
      rw_q    <= rw_d;
      oe_q    <= oe_d;
      ptr_q   <= ptr_d;
    end
  end

  // ****************************************
  // configuration store and embedded mirror
  // ****************************************
  logic       cfg_wr_ok;
  logic [7:0] emb_byte_d;
  logic       emb_on;

  // id bytes and the limit region never take writes
  assign cfg_wr_ok = wr_en && ptr_q[15:12] == ssp_pkg::REGION_CFG && ptr_q < 16'(CFG_DEPTH)
                     && ptr_q != ssp_pkg::ID_HI_ADDR && ptr_q != ssp_pkg::ID_LO_ADDR; // RQ3 RQ4 RQ5
  assign emb_on    = cfg_mem[ssp_pkg::EMB_CTRL_ADDR[$clog2(CFG_DEPTH)-1:0]][ssp_pkg::EMB_EN_BIT];

  always_comb begin
    // zero stands in for the unspecified bytes when mirroring is off
    emb_byte_d = ssp_pkg::RESET_BYTE; // RQ13
    if (emb_on && emb_idx < 8'(CFG_DEPTH) && EMB_FLAGS[emb_idx[5:0]]) begin
      emb_byte_d = cfg_mem[emb_idx[$clog2(CFG_DEPTH)-1:0]]; // RQ12
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      emb_byte_q  <= 8'h00;
      emb_valid_q <= 1'b0;
    end else begin
      emb_byte_q  <= emb_rd ? emb_byte_d : emb_byte_q;
      emb_valid_q <= emb_rd;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < CFG_DEPTH; gi++) begin : g_cfg
      always_ff @(posedge clk) begin
        if (reset) begin
          cfg_mem[gi] <= ssp_pkg::RESET_BYTE;
        end else if (cfg_wr_ok && ptr_q[$clog2(CFG_DEPTH)-1:0] == gi) begin
          cfg_mem[gi] <= sh_q; // RQ6
        end
      end
      assign cfg_q[gi*8 +: 8] = cfg_mem[gi];
    end
  endgenerate

  assign link.dev_sda_o  = 1'b0;
  assign link.dev_sda_oe = oe_q;
  assign link.dev_scl_o  = 1'b0;
  assign link.dev_scl_oe = 1'b0;
  assign busy            = state_q != ST_IDLE;
endmodule // ssp_device

// file: rtl/ssp_host.sv
`timescale 1ns/10ps
module ssp_host #(
  parameter int QTR = ssp_pkg::QTR_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset,
  ssp_if.host              link,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic        cmd_read,
  input  wire logic [6:0]  cmd_dev_addr,
  input  wire logic [15:0] cmd_reg_addr,
  input  wire logic [7:0]  cmd_wdata,
  output logic             resp_valid_q,
  output logic [7:0]       resp_rdata_q,
  output logic             resp_nack_q
);
  // ****************************************
  // quarter-bit enable and sda sampling
  // ****************************************
  typedef enum logic [3:0] {
    HS_IDLE  = 4'b0001,
    HS_START = 4'b0010,
    HS_BITS  = 4'b0100,
    HS_STOP  = 4'b1000
  } ssp_host_state_t;

  logic [15:0] div_q, div_d;
  logic        tick;
  logic [1:0]  sda_sync_q, sda_sync_d;

  assign tick = div_q == 16'(QTR - 1);

  always_comb begin
    div_d      = tick ? 16'h0000 : div_q + 16'h0001;
    sda_sync_d = {sda_sync_q[0], link.sda};
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      div_q      <= 16'h0000;
      sda_sync_q <= 2'b11;
    end else begin
      div_q      <= div_d;
      sda_sync_q <= sda_sync_d;
    end
  end

  // ****************************************
  // master sequencer
  // ****************************************
  ssp_host_state_t state_q, state_d;
  logic [1:0]  ph_q, ph_d;
  logic [3:0]  bit_q, bit_d;
  logic [2:0]  step_q, step_d;
  logic [7:0]  tx_q, tx_d, rx_q, rx_d;
  logic        ack_q, ack_d, rd_q, rd_d, nack_q, nack_d;
  logic [6:0]  dev_q, dev_d;
  logic [15:0] reg_q, reg_d;
  logic [7:0]  wd_q, wd_d;
  logic        scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
  logic        done;
  logic [7:0]  next_tx;

  always_comb begin
    case (step_d)
      3'd0: next_tx = {dev_d, 1'b0}; // RQ9
      3'd1: next_tx = reg_d[15:8]; // RQ2
      3'd2: next_tx = reg_d[7:0];
      3'd3: next_tx = wd_d;
      default: next_tx = {dev_d, 1'b1};
    endcase
  end

  always_comb begin
    state_d  = state_q;
    ph_d     = ph_q;
    bit_d    = bit_q;
    step_d   = step_q;
    tx_d     = tx_q;
    rx_d     = rx_q;
    ack_d    = ack_q;
    rd_d     = rd_q;
    nack_d   = nack_q;
    dev_d    = dev_q;
    reg_d    = reg_q;
    wd_d     = wd_q;
    scl_oe_d = scl_oe_q;
    sda_oe_d = sda_oe_q;
    done     = 1'b0;
    case (state_q)
      HS_IDLE: begin
        if (cmd_valid) begin
          dev_d   = cmd_dev_addr; // RQ10
          reg_d   = cmd_reg_addr;
          wd_d    = cmd_wdata;
          rd_d    = cmd_read;
          nack_d  = 1'b0;
          step_d  = 3'd0;
          ph_d    = 2'd0;
          state_d = HS_START;
        end
      end
      HS_START: if (tick) begin // RQ1
        ph_d = ph_q + 2'd1;
        case (ph_q)
          2'd0: sda_oe_d = 1'b0;
          2'd1: scl_oe_d = 1'b0;
          2'd2: sda_oe_d = 1'b1;
          default: begin
            scl_oe_d = 1'b1;
            bit_d    = 4'h0;
            tx_d     = next_tx;
            state_d  = HS_BITS;
          end
        endcase
      end
      HS_BITS: if (tick) begin
        ph_d = ph_q + 2'd1;
        case (ph_q)
          2'd0: sda_oe_d = (bit_q == 4'h8) ? (step_q != 3'd5 ? 1'b0 : 1'b0)
                           : (step_q != 3'd5 && !tx_q[7]);
          2'd1: scl_oe_d = 1'b0;
          2'd2: begin
            if (bit_q == 4'h8) begin
              ack_d = sda_sync_q[1];
            end else begin
              rx_d = {rx_q[6:0], sda_sync_q[1]};
            end
          end
          default: begin
            scl_oe_d = 1'b1;
            if (bit_q != 4'h8) begin
              bit_d = bit_q + 4'h1;
              tx_d  = {tx_q[6:0], 1'b0};
              // let go of data with the clock fall, before the receiver acknowledges
              if (bit_q == 4'h7) begin
                sda_oe_d = 1'b0;
              end
            end else if (step_q != 3'd5 && ack_q) begin
              nack_d  = 1'b1;
              state_d = HS_STOP;
            end else if (step_q == 3'd3 || step_q == 3'd5) begin
              state_d = HS_STOP;
            end else if (step_q == 3'd2 && rd_q) begin
              step_d  = 3'd4;
              state_d = HS_START;
            end else begin
              step_d = step_q + 3'd1;
              bit_d  = 4'h0;
              tx_d   = next_tx;
            end
          end
        endcase
      end
      default: if (tick) begin
        ph_d = ph_q + 2'd1;
        case (ph_q)
          2'd0: sda_oe_d = 1'b1;
          2'd1: scl_oe_d = 1'b0;
          2'd2: begin
            sda_oe_d = 1'b0;
            done     = 1'b1;
            ph_d     = 2'd0;
            state_d  = HS_IDLE;
          end
          default: ph_d = 2'd0;
        endcase
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q      <= HS_IDLE;
      ph_q         <= 2'd0;
      bit_q        <= 4'h0;
      step_q       <= 3'd0;
      tx_q         <= 8'h00;
      rx_q         <= 8'h00;
      ack_q        <= 1'b0;
      rd_q         <= 1'b0;
      nack_q       <= 1'b0;
      dev_q        <= 7'h00;
      reg_q        <= 16'h0000;
      wd_q         <= 8'h00;
      scl_oe_q     <= 1'b0;
      sda_oe_q     <= 1'b0;
      resp_valid_q <= 1'b0;
      resp_rdata_q <= 8'h00;
      resp_nack_q  <= 1'b0;
    end else begin
      state_q      <= state_d;
      ph_q         <= ph_d;
      bit_q        <= bit_d;
      step_q       <= step_d;
      tx_q         <= tx_d;
      rx_q         <= rx_d;
      ack_q        <= ack_d;
      rd_q         <= rd_d;
      nack_q       <= nack_d;
      dev_q        <= dev_d;
      reg_q        <= reg_d;
      wd_q         <= wd_d;
      scl_oe_q     <= scl_oe_d;
      sda_oe_q     <= sda_oe_d;
      resp_valid_q <= done;
      resp_rdata_q <= done ? rx_q : resp_rdata_q;
      resp_nack_q  <= done ? nack_q : resp_nack_q;
    end
  end

  // open drain: drive low only, no clock stretching expected
  assign link.host_scl_o  = 1'b0;
  assign link.host_scl_oe = scl_oe_q;
  assign link.host_sda_o  = 1'b0;
  assign link.host_sda_oe = sda_oe_q;
  assign cmd_ready        = state_q == HS_IDLE;
endmodule // ssp_host

// file: test/ssp_link_checker.sv
`timescale 1ns/10ps
module ssp_link_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_scl_o,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe
);
  // ********************
  // bus conditions
  // ********************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence start_s;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence stop_s;
    scl && $past(scl) && $rose(sda);
  endsequence
  // ********************
  // wire rules
  // ********************
  // no stretching: the host never waits for a slow device
  no_stretch_a: assert property (!dev_scl_oe)
    else $error("device drove the clock line");
  open_drain_a: assert property (!host_scl_o && !host_sda_o && !dev_sda_o && !dev_scl_o)
    else $error("driver output not low");
  reset_idle_a: assert property (disable iff (1'b0) reset |=> !(host_scl_oe || host_sda_oe || dev_sda_oe))
    else $error("bus not released after reset");
  dev_edge_a: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device changed data while clock high");
  start_quiet_a: assert property (start_s |-> !dev_sda_oe [*4])
    else $error("device drove data right after start");
  share_a: assert property (dev_sda_oe |-> !host_sda_oe)
    else $error("both ends drive data");
  low_width_a: assert property ($rose(host_scl_oe) |=> host_scl_oe [*5])
    else $error("clock low phase too short");
  high_width_a: assert property ($fell(host_scl_oe) |=> !host_scl_oe [*5])
    else $error("clock high phase too short");
  stop_free_a: assert property (stop_s |=> !dev_sda_oe [*4])
    else $error("device drove data after stop");
endmodule // ssp_link_checker

// file: test/sensor_register_serial_port_tb_top.sv
`timescale 1ns/10ps
module sensor_register_serial_port_tb_top;
  // ********************
  // setup
  // ********************
  localparam logic [6:0]  A_LO  = 7'h10;
  localparam logic [6:0]  A_HI  = 7'h1a;
  localparam logic [15:0] ID_TB = 16'h1234; // arbitrary value
  localparam logic [31:0] LIM   = 32'h8844_2211;
  localparam int          SN    = 16;
  typedef struct packed {logic rd; logic [7:0] d; logic n;} ssp_exp_t;
  logic             clk, reset, strap, cmd_valid, cmd_ready, cmd_read, emb_rd, emb_valid_q;
  logic             resp_valid_q, resp_nack_q, busy;
  logic [6:0]       cmd_dev_addr;
  logic [15:0]      cmd_reg_addr, a;
  logic [7:0]       cmd_wdata, resp_rdata_q, emb_idx, emb_byte_q, sh, d;
  logic [SN*14-1:0] stats;
  logic [511:0]     cfg_q;
  logic             scl_p = 1'b1;
  logic             sda_p = 1'b1;
  logic             scl, sda;
  logic [7:0]       w2, w3f;
  ssp_exp_t         rq[$];
  ssp_exp_t         ex;
  logic [7:0]       aq[$];
  logic [7:0]       eq[$];
  int               n_mismatch = 0;
  int               n_checks = 0;
  int               bitn = -1;
  int               i;
  ssp_if u_ssp_if ();
  assign scl = u_ssp_if.scl;
  assign sda = u_ssp_if.sda;
  ssp_device #(.ADDR_STRAP_LOW(A_LO), .ADDR_STRAP_HIGH(A_HI), .MODEL_ID(ID_TB), .LIMIT_WORD(LIM)) u_ssp_device (
    .clk(clk), .reset(reset), .link(u_ssp_if), .address_select_strap(strap), .stats_avg(stats),
    .emb_rd(emb_rd), .emb_idx(emb_idx), .emb_byte_q(emb_byte_q), .emb_valid_q(emb_valid_q),
    .cfg_q(cfg_q), .busy(busy));
  // short quarters keep the run small; device sync and checker widths need at least 3
  ssp_host #(.QTR(6)) u_ssp_host (
    .clk(clk), .reset(reset), .link(u_ssp_if), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_read(cmd_read), .cmd_dev_addr(cmd_dev_addr), .cmd_reg_addr(cmd_reg_addr), .cmd_wdata(cmd_wdata),
    .resp_valid_q(resp_valid_q), .resp_rdata_q(resp_rdata_q), .resp_nack_q(resp_nack_q));
  ssp_link_checker u_ssp_link_checker (
    .clk(clk), .reset(reset), .scl(u_ssp_if.scl), .sda(u_ssp_if.sda),
    .host_scl_o(u_ssp_if.host_scl_o), .host_scl_oe(u_ssp_if.host_scl_oe),
    .host_sda_o(u_ssp_if.host_sda_o), .host_sda_oe(u_ssp_if.host_sda_oe),
    .dev_scl_o(u_ssp_if.dev_scl_o), .dev_scl_oe(u_ssp_if.dev_scl_oe),
    .dev_sda_o(u_ssp_if.dev_sda_o), .dev_sda_oe(u_ssp_if.dev_sda_oe));
  always #4 clk = ~clk;
  // ********************
  // tasks
  // ********************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (rq.size() != 0 || aq.size() != 0 || eq.size() != 0) begin
      n_mismatch++;
      $display("CHECK FAILED %0t results still pending", $time);
    end
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic do_reset(input logic s);
    strap = s;
    reset = 1'b1;
    repeat (10) @(posedge clk);
    #1 reset = 1'b0;
    repeat (6) @(posedge clk);
    #1;
  endtask
  // entered just after an edge with the host idle
  task automatic xfer(input logic rd, input logic [6:0] dev, input logic [15:0] ra, input logic [7:0] wd,
                      input logic [7:0] ed, input logic en);
    int k;
    k = 0;
    rq.push_back('{rd, ed, en});
    aq.push_back({dev, 1'b0});
    if (rd && !en) aq.push_back({dev, 1'b1});
    cmd_read = rd;
    cmd_dev_addr = dev;
    cmd_reg_addr = ra;
    cmd_wdata = wd;
    cmd_valid = 1'b1;
    @(posedge clk);
    #1 cmd_valid = 1'b0;
    while (rq.size() != 0 && k < 5000) begin
      @(posedge clk);
      #1 k++;
    end
    repeat (3) @(posedge clk);
    #1 chk({7'h00, busy}, 8'h00, "busy after stop");
  endtask
  task automatic emb(input logic [7:0] idx, input logic [7:0] ed);
    eq.push_back(ed);
    emb_idx = idx;
    emb_rd = 1'b1;
    @(posedge clk);
    #1 emb_rd = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // ********************
  // watchers
  // ********************
  always @(posedge clk) begin
    if (resp_valid_q === 1'b1) begin
      ex = rq.pop_front();
      chk({7'h00, resp_nack_q}, {7'h00, ex.n}, "acknowledge");
      if (ex.rd && !ex.n) chk(resp_rdata_q, ex.d, "read data");
    end
    if (emb_valid_q === 1'b1) chk(emb_byte_q, eq.pop_front(), "embedded byte");
  end
  // first byte after each start: address then direction, msb first
  always @(posedge clk) begin
    if (scl && scl_p && sda_p && !sda) begin
      bitn = 0;
    end else if (scl && !scl_p && bitn >= 0) begin
      sh = {sh[6:0], sda};
      bitn++;
      if (bitn == 8) begin
        chk(sh, aq.pop_front(), "address byte");
        bitn = -1;
      end
    end
    scl_p = u_ssp_if.scl;
    sda_p = u_ssp_if.sda;
  end
  initial begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end
  // ********************
  // scenarios
  // ********************
  initial begin
    void'($urandom(81));
    clk = 1'b0;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_dev_addr = 7'h00;
    cmd_reg_addr = 16'h0000;
    cmd_wdata = 8'h00;
    emb_rd = 1'b0;
    emb_idx = 8'h00;
    for (i = 0; i < SN; i++) stats[i*14 +: 14] = 14'($urandom());
    do_reset(1'b0);
    xfer(1'b0, A_LO, 16'h0000, 8'h5a, 8'h00, 1'b0);
    xfer(1'b1, A_LO, 16'h0000, 8'h00, ID_TB[15:8], 1'b0);
    xfer(1'b1, A_LO, 16'h0001, 8'h00, ID_TB[7:0], 1'b0);
    for (i = 0; i < 5; i++) begin
      a = (i == 4) ? 16'h003f : 16'(i + 2);
      d = 8'($urandom());
      if (i == 0) w2 = d;
      if (i == 4) w3f = d;
      xfer(1'b0, A_LO, a, d, 8'h00, 1'b0);
      xfer(1'b1, A_LO, a, 8'h00, d, 1'b0);
      chk(cfg_q[a[5:0]*8 +: 8], d, "config byte");
    end
    // read-only, reserved, maker and unbacked config places: writes must leave them alone
    for (i = 0; i < 7; i++) begin
      a = (i < 4) ? (16'h1000 + 16'(i)) : (i == 4) ? 16'h2000 : (i == 5) ? 16'hffff : 16'h0040;
      xfer(1'b0, A_LO, a, 8'($urandom()), 8'h00, 1'b0);
      xfer(1'b1, A_LO, a, 8'h00, (i < 4) ? LIM[8*i +: 8] : 8'h00, 1'b0);
    end
    for (i = 0; i < SN; i += SN - 1) begin
      xfer(1'b1, A_LO, 16'h3000 + 16'(2*i), 8'h00, {2'b00, stats[i*14+8 +: 6]}, 1'b0);
      xfer(1'b1, A_LO, 16'h3001 + 16'(2*i), 8'h00, stats[i*14 +: 8], 1'b0);
    end
    xfer(1'b0, A_LO, 16'h0010, 8'h01, 8'h00, 1'b0);
    emb(8'h02, w2);
    emb(8'h3f, w3f);
    xfer(1'b0, A_LO, 16'h0010, 8'h00, 8'h00, 1'b0);
    emb(8'h02, 8'h00);
    xfer(1'b0, A_HI, 16'h0002, 8'h77, 8'h00, 1'b1);
    xfer(1'b1, 7'h55, 16'h0002, 8'h00, 8'h00, 1'b1);
    chk(cfg_q[23:16], w2, "config kept");
    // second reset mid-run, strap now high
    do_reset(1'b1);
    xfer(1'b1, A_HI, 16'h0002, 8'h00, 8'h00, 1'b0);
    xfer(1'b1, A_LO, 16'h0001, 8'h00, 8'h00, 1'b1);
    xfer(1'b1, A_HI, 16'h0001, 8'h00, ID_TB[7:0], 1'b0);
    wrap_up();
  end
endmodule // sensor_register_serial_port_tb_top
